// ---- nvh_pkg.sv ----
package nvh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing figures, in ns unless named otherwise
  localparam int CLK_PERIOD_NS              = 100;
  localparam int STORE_PULSE_MIN_NS         = 100;
  localparam int RECALL_PULSE_WINDOW_MIN_NS = 100;
  localparam int RECALL_PULSE_WINDOW_MAX_NS = 1000;
  localparam int RECALL_DURATION_MAX_US     = 5;
  localparam int STORE_DURATION_MAX_MS      = 5;
  localparam int SELECT_ACCESS_DELAY_NS     = 150;
  localparam int DRIVE_ACCESS_DELAY_NS      = 50;
  localparam int UNDRIVE_FLOAT_DELAY_NS     = 80;
  localparam int WRITE_FLOAT_DELAY_NS       = 80;
  localparam int SELECT_TO_WRITE_END_NS     = 150;
  localparam int DATA_BEFORE_WRITE_END_NS   = 100;
  localparam int POST_WRITE_DRIVE_DELAY_NS  = 5;

  // Least times round up, longest times round down, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int STORE_PULSE_CYC  = cyc_min(STORE_PULSE_MIN_NS);
  localparam int RECALL_PULSE_CYC = cyc_min(RECALL_PULSE_WINDOW_MIN_NS);
  localparam int RECALL_PULSE_MAX = cyc_max(RECALL_PULSE_WINDOW_MAX_NS);
  localparam int RECALL_WAIT_CYC  = cyc_min(RECALL_DURATION_MAX_US * 1000);
  localparam int STORE_WAIT_CYC   = cyc_min(STORE_DURATION_MAX_MS * 1000000);
  localparam int READ_WAIT_CYC    = cyc_min(SELECT_ACCESS_DELAY_NS);
  localparam int WRITE_PULSE_CYC  = cyc_min(SELECT_TO_WRITE_END_NS);
  localparam int FLOAT_WAIT_CYC   = cyc_min(UNDRIVE_FLOAT_DELAY_NS);
  localparam int POST_WRITE_CYC   = cyc_min(POST_WRITE_DRIVE_DELAY_NS);
  localparam int TIMER_W          = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths and command codes
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  typedef enum logic [1:0] {
    NVH_CMD_READ   = 2'h0,
    NVH_CMD_WRITE  = 2'h1,
    NVH_CMD_STORE  = 2'h2,
    NVH_CMD_RECALL = 2'h3
  } nvh_cmd_t;

  typedef struct packed {
    nvh_cmd_t          cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvh_req_t;

  // Active-low control pins toward the memory
  typedef struct packed {
    logic chip_en_n;
    logic out_en_n;
    logic write_en_n;
    logic nv_access_n;
  } nvh_ctl_t;

  localparam nvh_ctl_t CTL_IDLE = 4'hf;

endpackage

// ---- nvh_ctrl.sv ----
// Function
// RQ1: A store is started by holding nv enable, write enable and chip enable low together at least 100 ns; it finishes within 5 ms.
// RQ2: A recall is started by holding nv enable, output enable and chip enable low together at least 0.1 us.
// RQ3: The recall pulse is kept no longer than 1 us.
// RQ4: A recall finishes within 5 us and recalled data is not used before then.
// RQ5: For a store, nv enable falls no later than write enable.
// RQ6: The memory floats its data pins within 80 ns of nv enable falling.
// RQ7: Read data is valid at most 150 ns after chip enable falls.
// RQ8: Read data is valid at most 50 ns after output enable falls.
// RQ9: The memory floats its data within 80 ns after chip enable rises.
// RQ10: The memory floats its data within 80 ns after output enable rises.
// RQ11: The memory floats its data within 80 ns after write enable falls.
// RQ12: The memory drives again no sooner than 5 ns after a write ends.
// RQ13: Chip enable is low at least 150 ns before a write ends.
// RQ14: Write data is stable at least 100 ns before a write ends.
// RQ15: Read data stays valid at least 0 ns after the address changes.
// RQ16: All further accesses are blocked until the store or recall time has elapsed.
module nvh_ctrl
  import nvh_pkg::*;
#(
  parameter int STORE_WAIT = STORE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_b,
  // Request side
  input  wire logic                  i_req_valid,
  input  wire nvh_pkg::nvh_req_t     i_req,
  output logic                       o_req_ready,
  output logic                       o_rdata_valid,
  output logic [nvh_pkg::DATA_W-1:0] o_rdata,
  output logic                       o_busy,
  // Memory pins
  output nvh_pkg::nvh_ctl_t          o_ctl,
  output logic [nvh_pkg::ADDR_W-1:0] o_addr,
  output logic [nvh_pkg::DATA_W-1:0] o_dq_out,
  output logic                       o_dq_oe,
  input  wire logic [nvh_pkg::DATA_W-1:0] i_dq_in
);
  import nvh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data pins through three flops; accept once stages two and three agree
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;
  logic [DATA_W-1:0] dq_s3_reg;
  always_ff @(posedge i_clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
      dq_s3_reg <= '0;
    end else begin
      dq_s1_reg <= i_dq_in;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
    end
  end
  logic dq_stable;
  assign dq_stable = (dq_s2_reg == dq_s3_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_PULSE  = 3'h3,
    ST_SAMPLE = 3'h2,
    ST_END    = 3'h6,
    ST_WAIT   = 3'h7
  } nvh_state_t;

  nvh_state_t        state_reg,  state_next;
  nvh_cmd_t          cmd_reg,    cmd_next;
  nvh_ctl_t          ctl_reg,    ctl_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0] wdata_reg,  wdata_next;
  logic              dq_oe_reg,  dq_oe_next;
  logic [DATA_W-1:0] rdata_reg,  rdata_next;
  logic              rvalid_reg, rvalid_next;
  logic [TIMER_W-1:0] tmr_reg,   tmr_next;
  logic [31:0]       busy_cnt_reg, busy_cnt_next;

  // Pulse length of the active phase for each command
  function automatic logic [TIMER_W-1:0] pulse_len(input nvh_cmd_t c);
    unique case (c)
      NVH_CMD_READ:   pulse_len = TIMER_W'(READ_WAIT_CYC + 2);
      NVH_CMD_WRITE:  pulse_len = TIMER_W'(WRITE_PULSE_CYC);
      NVH_CMD_STORE:  pulse_len = TIMER_W'(STORE_PULSE_CYC);
      NVH_CMD_RECALL: pulse_len = TIMER_W'(RECALL_PULSE_CYC);
    endcase
  endfunction

  // Next-state logic; long waits keep the bus idle so no access overlaps
  always_comb begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    ctl_next      = ctl_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    dq_oe_next    = dq_oe_reg;
    rdata_next    = rdata_reg;
    rvalid_next   = 1'b0;
    tmr_next      = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
    busy_cnt_next = (busy_cnt_reg != '0) ? busy_cnt_reg - 1'b1 : busy_cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (i_req_valid) begin
          cmd_next   = i_req.cmd;
          addr_next  = i_req.addr;
          wdata_next = i_req.wdata;
          state_next = ST_SETUP;
          // NV enable goes low first, before write or output enable [RQ5]
          ctl_next.nv_access_n = !((i_req.cmd == NVH_CMD_STORE) || (i_req.cmd == NVH_CMD_RECALL));
          ctl_next.chip_en_n   = 1'b0;                                  // [RQ13]
          // Drive write data a full pulse ahead of the write end [RQ14]
          dq_oe_next = (i_req.cmd == NVH_CMD_WRITE);
        end
      end
      ST_SETUP: begin
        state_next = ST_PULSE;
        tmr_next   = pulse_len(cmd_reg);
        unique case (cmd_reg)
          NVH_CMD_READ:   ctl_next.out_en_n   = 1'b0;
          NVH_CMD_WRITE:  ctl_next.write_en_n = 1'b0;
          NVH_CMD_STORE:  ctl_next.write_en_n = 1'b0;                   // [RQ1]
          NVH_CMD_RECALL: ctl_next.out_en_n   = 1'b0;                   // [RQ2]
        endcase
      end
      ST_PULSE: begin
        // Recall pulse ends long before the 1 us ceiling [RQ3]
        if (tmr_reg == '0) begin
          state_next = (cmd_reg == NVH_CMD_READ) ? ST_SAMPLE : ST_END;
        end
      end
      ST_SAMPLE: begin
        // Data sampled well after the access delays have run out [RQ7] [RQ8]
        if (dq_stable) begin
          rdata_next  = dq_s3_reg;
          rvalid_next = 1'b1;
          state_next  = ST_END;
        end
      end
      ST_END: begin
        ctl_next   = CTL_IDLE;
        dq_oe_next = 1'b0;
        state_next = ST_WAIT;
        // Hold off further access for store or recall completion [RQ16]
        unique case (cmd_reg)
          NVH_CMD_STORE:  busy_cnt_next = 32'(STORE_WAIT);              // [RQ1]
          NVH_CMD_RECALL: busy_cnt_next = 32'(RECALL_WAIT_CYC);         // [RQ4]
          default:        busy_cnt_next = 32'(FLOAT_WAIT_CYC + POST_WRITE_CYC);
        endcase
      end
      ST_WAIT: begin
        // Also lets the memory float its pins before the next cycle [RQ10]
        if (busy_cnt_reg <= 32'h1) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg    <= ST_IDLE;
      cmd_reg      <= NVH_CMD_READ;
      ctl_reg      <= CTL_IDLE;
      addr_reg     <= '0;
      wdata_reg    <= '0;
      dq_oe_reg    <= 1'b0;
      rdata_reg    <= '0;
      rvalid_reg   <= 1'b0;
      tmr_reg      <= '0;
      busy_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      ctl_reg      <= ctl_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      dq_oe_reg    <= dq_oe_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      tmr_reg      <= tmr_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_req_ready   = (state_reg == ST_IDLE);
  assign o_busy        = (state_reg != ST_IDLE);
  assign o_rdata_valid = rvalid_reg;
  assign o_rdata       = rdata_reg;
  assign o_ctl         = ctl_reg;
  assign o_addr        = addr_reg;
  assign o_dq_out      = wdata_reg;
  assign o_dq_oe       = dq_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_sync_reg);

  store_pulse_len_a: assert property ( // [RQ1]
    $fell(o_ctl.write_en_n) && !o_ctl.nv_access_n |->
      (!o_ctl.write_en_n && !o_ctl.nv_access_n && !o_ctl.chip_en_n) [*2])
    else $error("store pulse too short");
  recall_pulse_len_a: assert property ( // [RQ2]
    $fell(o_ctl.out_en_n) && !o_ctl.nv_access_n |->
      (!o_ctl.out_en_n && !o_ctl.nv_access_n) [*2])
    else $error("recall pulse too short");
  recall_pulse_max_a: assert property ( // [RQ3]
    $fell(o_ctl.out_en_n) && !o_ctl.nv_access_n |-> ##[1:8] o_ctl.out_en_n)
    else $error("recall pulse too long");
  recall_hold_off_a: assert property ( // [RQ4]
    $rose(o_ctl.nv_access_n) && (cmd_reg == NVH_CMD_RECALL) |-> !o_req_ready [*8])
    else $error("recall wait cut short");
  nv_before_we_a: assert property ( // [RQ5]
    $fell(o_ctl.write_en_n) && (cmd_reg == NVH_CMD_STORE) |-> !$past(o_ctl.nv_access_n))
    else $error("nv enable late for store");
  write_data_setup_a: assert property ( // [RQ14]
    $rose(o_ctl.write_en_n) && (cmd_reg == NVH_CMD_WRITE) |-> $past(o_dq_oe, 2))
    else $error("write data setup short");
  write_select_a: assert property ( // [RQ13]
    !o_ctl.write_en_n |-> !o_ctl.chip_en_n)
    else $error("write without chip enable");
  no_contention_a: assert property ( // [RQ11]
    o_dq_oe |-> o_ctl.out_en_n)
    else $error("bus contention");
  read_done_a: assert property ( // [RQ7]
    $fell(o_ctl.out_en_n) && o_ctl.nv_access_n |-> ##[3:20] o_rdata_valid)
    else $error("read never completes");

  cover_read_c:   cover property (o_rdata_valid);
  cover_write_c:  cover property ($rose(o_ctl.write_en_n) && cmd_reg == NVH_CMD_WRITE);
  cover_store_c:  cover property ($rose(o_ctl.write_en_n) && cmd_reg == NVH_CMD_STORE);
  cover_recall_c: cover property ($rose(o_ctl.out_en_n) && cmd_reg == NVH_CMD_RECALL);

endmodule

// ---- nvh_mem_model.sv ----
module nvh_mem_model #(
  parameter int STORE_NS = 10000
) (
  // Control pins, active low
  input  wire logic                       i_ce_n,
  input  wire logic                       i_oe_n,
  input  wire logic                       i_we_n,
  input  wire logic                       i_ne_n,
  // Address and data as seen on the wire
  input  wire logic [nvh_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [nvh_pkg::DATA_W-1:0] i_dq,
  input  wire logic                       i_host_oe,
  // Memory side of the data pins
  output logic      [nvh_pkg::DATA_W-1:0] o_dq,
  output logic                            o_drive,
  output logic                            o_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  import nvh_pkg::*;

  logic    [DATA_W-1:0] ram [512];
  logic    [DATA_W-1:0] nvm [512];
  logic    [DATA_W-1:0] flt;
  logic    [DATA_W-1:0] wlat;
  logic    [ADDR_W-1:0] wadr;
  realtime              t_ce   = 0;
  realtime              t_busy = 0;
  realtime              t_wr   = -1;
  realtime              t_st   = -1;
  realtime              t_rc   = -1;
  wire                  rd = !i_ce_n && !i_oe_n && i_we_n && i_ne_n;
  wire                  wr = !i_ce_n && !i_we_n && i_oe_n && i_ne_n;
  wire                  st = !i_ce_n && !i_we_n && i_oe_n && !i_ne_n;
  wire                  rc = !i_ce_n && !i_oe_n && i_we_n && !i_ne_n;
  wire                  clash = o_drive & i_host_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Drive within both access limits, float well inside the release limits
  assign #(40, 20) o_drive = rd;
  // Released pins show the inverse of the last byte, never a stale copy
  assign o_dq = o_drive ? ram[i_addr] : flt;
  initial begin
    o_bad = 1'b0;
    flt   = 8'h00;
  end
  always @(negedge o_drive) flt = ~ram[i_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Access during a store or recall, and host clashing with our drivers
  always @(negedge i_ce_n) begin
    if ($realtime < t_busy) o_bad = 1'b1;
    t_ce = $realtime;
  end
  always @(posedge clash) o_bad = 1'b1;
  // Nonvolatile enable must not fall after write enable
  always @(negedge i_ne_n) if (!i_we_n) o_bad = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Write latches 90 ns into the pulse so the host's data has settled
  always @(posedge wr) begin
    t_wr = $realtime;
    #90 wlat = i_dq;
    wadr = i_addr;
  end
  always @(negedge wr) if (t_wr >= 0) begin
    if ($realtime - t_ce < 150) o_bad = 1'b1;
    ram[wadr] = wlat;
    t_wr = -1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store and recall copy the whole array at the end of a good pulse
  always @(st) if (st === 1'b1) t_st = $realtime;
  else if (t_st >= 0) begin
    if ($realtime - t_st < 100) o_bad = 1'b1;
    else begin
      nvm = ram;
      t_busy = t_st + STORE_NS;
    end
    t_st = -1;
  end
  always @(rc) if (rc === 1'b1) t_rc = $realtime;
  else if (t_rc >= 0) begin
    if ($realtime - t_rc < 100 || $realtime - t_rc > 1000) o_bad = 1'b1;
    else begin
      ram = nvm;
      t_busy = t_rc + 5000;
    end
    t_rc = -1;
  end
endmodule

// ---- tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nvh_pkg::*;

  localparam int LIMIT = 5000;
  logic              i_clock;
  logic              i_rst_b;
  logic              i_req_valid;
  nvh_req_t          i_req;
  logic              o_req_ready;
  logic              o_rdata_valid;
  logic              o_busy;
  logic              o_dq_oe;
  logic              m_drive;
  logic              m_bad;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] o_dq_out;
  logic [DATA_W-1:0] m_dq;
  logic [DATA_W-1:0] dq_wire;
  logic [ADDR_W-1:0] o_addr;
  nvh_ctl_t          o_ctl;
  int                fail_count      = 0;
  int                samples_checked = 0;
  int                cycles          = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Host wins the wire while it drives, else the memory's pins show
  assign dq_wire = o_dq_oe ? o_dq_out : m_dq;
  nvh_ctrl #(.STORE_WAIT(100)) u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
    .o_busy(o_busy), .o_ctl(o_ctl), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
    .i_dq_in(dq_wire));
  nvh_mem_model #(.STORE_NS(100 * CLK_PERIOD_NS)) u_mem (.i_ce_n(o_ctl.chip_en_n),
    .i_oe_n(o_ctl.out_en_n), .i_we_n(o_ctl.write_en_n), .i_ne_n(o_ctl.nv_access_n), .i_addr(o_addr),
    .i_dq(dq_wire), .i_host_oe(o_dq_oe), .o_dq(m_dq), .o_drive(m_drive), .o_bad(m_bad));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling on the run that ends a hang
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares and the closing report
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One request, held until the edge where ready is high
  task automatic do_req(input nvh_cmd_t c, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clock);
    while (o_req_ready !== 1'b1 && n < 400) begin
      @(negedge i_clock);
      n++;
    end
    // A hold-off that never ends counts as a mismatch rather than a lost request
    chk1("req_ready", 1'b1, o_req_ready);
    @(posedge i_clock);
    i_req_valid <= 1'b1;
    i_req <= '{cmd: c, addr: a, wdata: d};
    @(posedge i_clock);
    i_req_valid <= 1'b0;
  endtask
  // Read back one byte; the answer pulse is caught in its single cycle
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    int   n;
    logic seen;
    do_req(NVH_CMD_READ, a, 8'h00);
    seen = 1'b0;
    n = 0;
    while (!seen && n < 20) begin
      @(posedge i_clock);
      seen = (o_rdata_valid === 1'b1);
      n++;
    end
    chk1("rdata_valid", 1'b1, seen);
    chk8("rdata", exp, o_rdata);
    // Pins went idle at this edge; the memory must have let go by mid-cycle
    @(negedge i_clock);
    chk1("mem_float", 1'b0, m_drive);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios: back-to-back writes at both address ends, then reads
  task automatic t_ramrw();
    do_req(NVH_CMD_WRITE, 9'h1ff, 8'ha5);
    do_req(NVH_CMD_WRITE, 9'h000, 8'h3c);
    rd_chk(9'h1ff, 8'ha5);
    rd_chk(9'h000, 8'h3c);
  endtask
  // Store, spoil RAM, recall, and see the stored image return
  task automatic t_nv();
    do_req(NVH_CMD_WRITE, 9'h005, 8'h77);
    do_req(NVH_CMD_STORE, 9'h000, 8'h00);
    repeat (50) @(negedge i_clock);
    chk1("busy_in_store", 1'b1, o_busy);
    do_req(NVH_CMD_WRITE, 9'h005, 8'h11);
    do_req(NVH_CMD_WRITE, 9'h1ff, 8'h00);
    rd_chk(9'h005, 8'h11);
    do_req(NVH_CMD_RECALL, 9'h000, 8'h00);
    rd_chk(9'h005, 8'h77);
    rd_chk(9'h1ff, 8'ha5);
    chk1("pin_protocol_fault", 1'b0, m_bad);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset with pins idle, then the scenarios
  initial begin
    i_rst_b = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    chk8("ctl_in_reset", {4'h0, CTL_IDLE}, {4'h0, o_ctl});
    chk1("dq_oe_in_reset", 1'b0, o_dq_oe);
    @(posedge i_clock);
    i_rst_b <= 1'b1;
    // Ready already reads high inside reset; let the two-flop release finish first
    repeat (3) @(posedge i_clock);
    t_ramrw();
    t_nv();
    conclude();
  end
endmodule
